// ==== hw/conv_ctrl_defs.vh ====
// Constants for the converter control block: pulse timing and widths.
// Assumes a 250 MHz system clock (4 ns period).
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS 4

// ----------------------------------------
// Strobe timing
// ----------------------------------------
// Fast grade strobe window, ns (falling edge before this)
`define FAST_WINDOW_NS 30
// Slow grade strobe window, ns
`define SLOW_WINDOW_NS 50
// Longest time rounds down, then one cycle margin stays strictly below
`define FAST_HIGH_CYC ((`FAST_WINDOW_NS / `CLK_PERIOD_NS) - 1)
`define SLOW_HIGH_CYC ((`SLOW_WINDOW_NS / `CLK_PERIOD_NS) - 1)
// Input settling interval before third flash step, ns
`define SETTLE_NS 200
// Least time rounds up
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Width of the strobe and timeout counters
`define CNT_W 16

// ----------------------------------------
// Result layout
// ----------------------------------------
`define DATA_W 12
`define MSB_POS 11
// Stored word: {range flag, 12 data bits}
`define WORD_W 13
`define FLAG_POS 12

`endif

// ==== hw/result_fifo.v ====
// Small synchronous FIFO holding captured conversion results.
// Assumes writer and reader share one clock; depth is a power of two.
`timescale 1ns/1ns
module result_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output reg [WIDTH-1:0] rd_data_o,
  output reg rd_valid_o,
  input wire rd_ready_i
);
  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Word storage
  reg [AW:0] wr_ptr_q; // Write pointer with wrap bit
  reg [AW:0] rd_ptr_q; // Read pointer with wrap bit
  wire [AW:0] fill; // Words held in memory
  wire full;
  wire mem_empty;
  wire pop; // Move one word into output register
  assign fill = wr_ptr_q - rd_ptr_q;
  assign full = (fill == DEPTH[AW:0]);
  assign mem_empty = (fill == {(AW+1){1'b0}});
  assign wr_ready_o = ~full;
  // Refill the output register when empty or being drained
  assign pop = ~mem_empty & (~rd_valid_o | rd_ready_i);

  // Memory write, no reset needed on data
  always @(posedge clk_i) begin
    if (wr_valid_i && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
    end
  end

  // Pointers and registered read side
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
      rd_data_o <= {WIDTH{1'b0}};
      rd_valid_o <= 1'b0;
    end else begin
      if (wr_valid_i && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        // Data out comes from a register
        rd_data_o <= mem_q[rd_ptr_q[AW-1:0]];
        rd_valid_o <= 1'b1;
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
    end
  end
endmodule // result_fifo

// ==== hw/conv_ctrl.v ====
// Host side controller for a 12-bit subranging converter: issues the
// conversion strobe, captures data and range flag on the result strobe,
// and streams results out through an 8 word FIFO.
// Assumes converter pins are asynchronous to CLK_I.
//
// Summary of operation
// - One short high strobe starts each conversion
// - Fast grade: strobe low within 30 ns
// - Slow grade: strobe low within 50 ns
// - Optionally drop strobe after result strobe falls
// - Input must settle within 200 ns
// - Capture data on result strobe rising edge
// - Flag plus MSB gives violation direction
`timescale 1ns/1ns
`include "conv_ctrl_defs.vh"
module conv_ctrl #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter [`CNT_W-1:0] TIMEOUT_CYC = 16'h0400
) (
  input wire CLK_I,
  input wire RESETN_I,
  input wire START_I,
  input wire SLOW_GRADE_I,
  input wire LATE_RELEASE_I,
  input wire TWOS_COMP_I,
  output reg CONV_STROBE_O,
  output reg SETTLED_O,
  input wire RESULT_VALID_STROBE_I,
  input wire [`DATA_W-1:0] DATA_I,
  input wire RANGE_EXCEEDED_FLAG_I,
  output reg BUSY_O,
  output reg TIMEOUT_O,
  output reg [`DATA_W-1:0] RESULT_O,
  output reg OVER_O,
  output reg UNDER_O,
  output reg RESULT_VALID_O,
  input wire RESULT_READY_I
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg dav_s1_q; // First stage, read only by second stage
  reg dav_s2_q;
  reg dav_s3_q; // Previous value for edge detection
  reg [`WORD_W-1:0] word_s1_q; // Data and flag, first stage
  reg [`WORD_W-1:0] word_s2_q;

  // Two flip-flops on every converter output
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dav_s1_q <= 1'b0;
      dav_s2_q <= 1'b0;
      dav_s3_q <= 1'b0;
      word_s1_q <= {`WORD_W{1'b0}};
      word_s2_q <= {`WORD_W{1'b0}};
    end else begin
      dav_s1_q <= RESULT_VALID_STROBE_I;
      dav_s2_q <= dav_s1_q;
      dav_s3_q <= dav_s2_q;
      word_s1_q <= {RANGE_EXCEEDED_FLAG_I, DATA_I};
      word_s2_q <= word_s1_q;
    end
  end

  wire dav_rise; // Result ready edge
  wire dav_fall; // Final stage finished
  assign dav_rise = dav_s2_q & ~dav_s3_q;
  assign dav_fall = ~dav_s2_q & dav_s3_q;

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1; // Waiting for a start
  localparam [3:0] ST_HIGH = 4'h2; // Strobe held high
  localparam [3:0] ST_WAIT = 4'h4; // Waiting for result strobe
  localparam [3:0] ST_TAIL = 4'h8; // Late release, wait for fall
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`CNT_W-1:0] cnt_q; // Strobe width / timeout counter
  reg [`CNT_W-1:0] cnt_d;
  reg late_q; // Late release chosen for this conversion
  wire [`CNT_W-1:0] high_cyc; // Strobe high length per grade
  wire push; // Result captured into FIFO
  wire fifo_ready;

  // Derived counts held at full width, then cut to the counter on purpose
  localparam [31:0] FAST_CYC_32 = `FAST_HIGH_CYC; // Fast grade high cycles
  localparam [31:0] SLOW_CYC_32 = `SLOW_HIGH_CYC; // Slow grade high cycles
  localparam [31:0] SETTLE_CYC_32 = `SETTLE_CYC; // Settling interval cycles

  assign high_cyc = SLOW_GRADE_I ? SLOW_CYC_32[`CNT_W-1:0] : FAST_CYC_32[`CNT_W-1:0];

  // Next state; a start waits for FIFO room so no result is lost
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = {`CNT_W{1'b0}};
        if (START_I && fifo_ready) begin
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        cnt_d = cnt_q + 1'b1;
        if (late_q) begin
          state_d = ST_WAIT;
        end else if (cnt_q >= high_cyc - 1'b1) begin
          state_d = ST_WAIT;
          cnt_d = {`CNT_W{1'b0}};
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if (dav_rise) begin
          state_d = late_q ? ST_TAIL : ST_IDLE;
        end else if (cnt_q == TIMEOUT_CYC) begin
          // Converter never answered; give up
          state_d = ST_IDLE;
        end
      end
      ST_TAIL: begin
        cnt_d = cnt_q + 1'b1;
        if (dav_fall || cnt_q == TIMEOUT_CYC) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign push = (state_q == ST_WAIT) && dav_rise;

  // State, strobe and status registers
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
      cnt_q <= {`CNT_W{1'b0}};
      late_q <= 1'b0;
      CONV_STROBE_O <= 1'b0;
      SETTLED_O <= 1'b0;
      BUSY_O <= 1'b0;
      TIMEOUT_O <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == ST_IDLE) begin
        late_q <= LATE_RELEASE_I;
      end
      CONV_STROBE_O <= (state_d == ST_HIGH) || (state_d == ST_WAIT && late_q)
                       || (state_d == ST_TAIL);
      SETTLED_O <= (state_q == ST_WAIT) && (cnt_q >= SETTLE_CYC_32[`CNT_W-1:0]);
      BUSY_O <= (state_d != ST_IDLE);
      // Timeout pulse marks a result strobe that never rose, or on late release never fell
      TIMEOUT_O <= (state_q == ST_WAIT || state_q == ST_TAIL) && !dav_rise
                   && !dav_fall && (cnt_q == TIMEOUT_CYC);
    end
  end

  // ----------------------------------------
  // Result buffering
  // ----------------------------------------
  wire [`WORD_W-1:0] fifo_out;
  wire fifo_out_valid;

  result_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .wr_data_i(word_s2_q),
    .wr_valid_i(push),
    .wr_ready_o(fifo_ready),
    .rd_data_o(fifo_out),
    .rd_valid_o(fifo_out_valid),
    .rd_ready_i(~RESULT_VALID_O | RESULT_READY_I)
  );

  // Output stage; twos complement just inverts the MSB of offset binary
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RESULT_O <= {`DATA_W{1'b0}};
      OVER_O <= 1'b0;
      UNDER_O <= 1'b0;
      RESULT_VALID_O <= 1'b0;
    end else if (!RESULT_VALID_O || RESULT_READY_I) begin
      RESULT_VALID_O <= fifo_out_valid;
      if (fifo_out_valid) begin
        RESULT_O <= {fifo_out[`MSB_POS] ^ TWOS_COMP_I, fifo_out[`MSB_POS-1:0]};
        OVER_O <= fifo_out[`FLAG_POS] & fifo_out[`MSB_POS];
        UNDER_O <= fifo_out[`FLAG_POS] & ~fifo_out[`MSB_POS];
      end
    end
  end
endmodule // conv_ctrl

// ==== verif/conv_ctrl_chk.sv ====
// Checker on the controller's ports; bound into conv_ctrl.
// Assumes grade and release mode stay steady through a conversion.
`timescale 1ns/1ns
module conv_ctrl_chk (
  input wire CLK_I,
  input wire RESETN_I,
  input wire START_I,
  input wire SLOW_GRADE_I,
  input wire LATE_RELEASE_I,
  input wire CONV_STROBE_O,
  input wire SETTLED_O,
  input wire RESULT_VALID_STROBE_I,
  input wire BUSY_O,
  input wire TIMEOUT_O,
  input wire [11:0] RESULT_O,
  input wire OVER_O,
  input wire UNDER_O,
  input wire RESULT_VALID_O,
  input wire RESULT_READY_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  reg [7:0] busy_run; // Cycles BUSY_O has stood high, saturating
  // Run length of the current conversion
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_run <= 8'h00;
    end else if (!BUSY_O) begin
      busy_run <= 8'h00;
    end else if (busy_run != 8'hFF) begin
      busy_run <= busy_run + 8'h01;
    end
  end
  // Settle flag only after 50 cycles (200 ns) of the conversion
  a_settle_delay: assert property (
    $rose(SETTLED_O) |-> busy_run >= 8'h32) else $error("settle flag too early");
  a_fast_width: assert property (
    $rose(CONV_STROBE_O) && !SLOW_GRADE_I && !LATE_RELEASE_I
    |-> CONV_STROBE_O [*6] ##1 !CONV_STROBE_O) else $error("fast strobe width wrong");
  a_slow_width: assert property (
    $rose(CONV_STROBE_O) && SLOW_GRADE_I && !LATE_RELEASE_I
    |-> (CONV_STROBE_O throughout ##10 1) ##1 !CONV_STROBE_O) else $error("slow strobe width");
  a_late_release: assert property (
    $fell(CONV_STROBE_O) && LATE_RELEASE_I |-> !RESULT_VALID_STROBE_I)
    else $error("strobe dropped before result strobe fell");
  a_strobe_cause: assert property (
    $rose(CONV_STROBE_O) |-> $past(START_I) && !$past(BUSY_O)) else $error("strobe without start");
  a_strobe_busy: assert property (
    CONV_STROBE_O |-> BUSY_O) else $error("strobe outside conversion");
  a_result_stands: assert property (
    RESULT_VALID_O && !RESULT_READY_I |=> RESULT_VALID_O && $stable(RESULT_O) && $stable(OVER_O))
    else $error("result changed while stalled");
  a_dir_exclusive: assert property (
    RESULT_VALID_O && (OVER_O || UNDER_O) |-> !(OVER_O && UNDER_O)
    && RESULT_O[10:0] == {11{OVER_O}}) else $error("range direction or data wrong");
  a_timeout_pulse: assert property (
    TIMEOUT_O |-> $past(BUSY_O) ##1 !TIMEOUT_O) else $error("timeout not a pulse");
endmodule // conv_ctrl_chk
bind conv_ctrl conv_ctrl_chk u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .START_I(START_I),
  .SLOW_GRADE_I(SLOW_GRADE_I), .LATE_RELEASE_I(LATE_RELEASE_I), .CONV_STROBE_O(CONV_STROBE_O),
  .SETTLED_O(SETTLED_O),
  .RESULT_VALID_STROBE_I(RESULT_VALID_STROBE_I), .BUSY_O(BUSY_O), .TIMEOUT_O(TIMEOUT_O),
  .RESULT_O(RESULT_O), .OVER_O(OVER_O), .UNDER_O(UNDER_O), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_READY_I(RESULT_READY_I));

// ==== verif/adc_model.sv ====
// Behavioural converter: answers each strobe after a settable delay unless mute_i is high.
// Assumes strobes never overlap a conversion in progress.
`timescale 1ns/1ns
module adc_model (
  input wire clk_i,
  input wire strobe_i,
  input wire signed [13:0] ain_i,
  input wire [7:0] lat_i,
  input wire mute_i,
  output reg rvs_o,
  output reg [11:0] data_o,
  output reg flag_o
);
  reg prev_q; // Strobe seen last cycle
  integer cnt_q; // Internal timing count
  initial begin
    prev_q = 1'b0;
    cnt_q = 0;
    rvs_o = 1'b0;
    data_o = 12'h000;
    flag_o = 1'b0;
  end
  always @(posedge clk_i) begin
    prev_q <= strobe_i;
    if (strobe_i && !prev_q && !mute_i) begin
      // Longer than the 6 or 11 cycle strobe, so the answer lands after it except on late release
      cnt_q <= lat_i + 16;
      data_o <= ~data_o; // Invalid pattern while converting
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
    if (cnt_q == 6) begin
      data_o <= (ain_i > 4095) ? 12'hFFF : (ain_i < 0) ? 12'h000 : ain_i[11:0];
      flag_o <= (ain_i > 4095) || (ain_i < 0);
    end
    rvs_o <= (cnt_q <= 5) && (cnt_q >= 2); // Data stays valid until next start
  end
endmodule // adc_model

// ==== verif/test_conv_ctrl.sv ====
// Bench for conv_ctrl with a converter model and a stalling consumer.
// Assumes a 4 ns clock and a short timeout parameter.
`timescale 1ns/1ns
module test_conv_ctrl;
  reg CLK_I, RESETN_I, START_I, SLOW_GRADE_I, LATE_RELEASE_I, TWOS_COMP_I, RESULT_READY_I;
  wire CONV_STROBE_O, SETTLED_O, BUSY_O, TIMEOUT_O, OVER_O, UNDER_O, RESULT_VALID_O, rvs, flag;
  wire [11:0] RESULT_O, data;
  reg signed [13:0] ain; // Level the model converts
  reg [7:0] lat;
  reg mute, stall, ok, settle_seen;
  reg [13:0] q[$]; // Expected {over, under, data}
  integer seed, n_mismatch, n_compared, n_tmo, i, p, n, a, k;
  conv_ctrl #(.TIMEOUT_CYC(16'h0040)) uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .START_I(START_I),
    .SLOW_GRADE_I(SLOW_GRADE_I), .LATE_RELEASE_I(LATE_RELEASE_I), .TWOS_COMP_I(TWOS_COMP_I),
    .CONV_STROBE_O(CONV_STROBE_O), .SETTLED_O(SETTLED_O), .RESULT_VALID_STROBE_I(rvs),
    .DATA_I(data), .RANGE_EXCEEDED_FLAG_I(flag), .BUSY_O(BUSY_O), .TIMEOUT_O(TIMEOUT_O),
    .RESULT_O(RESULT_O), .OVER_O(OVER_O), .UNDER_O(UNDER_O), .RESULT_VALID_O(RESULT_VALID_O),
    .RESULT_READY_I(RESULT_READY_I));
  adc_model dev (.clk_i(CLK_I), .strobe_i(CONV_STROBE_O), .ain_i(ain), .lat_i(lat),
    .mute_i(mute), .rvs_o(rvs), .data_o(data), .flag_o(flag));
  // Direction from the input range, sign bit flipped for twos complement
  function [13:0] expect_word(input integer v, input reg tc);
    reg [11:0] d;
    begin
      d = (v > 4095) ? 12'hFFF : (v < 0) ? 12'h000 : v[11:0];
      expect_word = {v > 4095, v < 0, d[11] ^ tc, d[10:0]};
    end
  endfunction
  task check(input reg good, input [8*24-1:0] msg);
    begin
      n_compared = n_compared + 1;
      if (!good) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: %0s", $time, msg);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Hold the start until taken or refused; then wait for idle
  task convert(input integer v, output reg taken);
    begin
      ain = v;
      START_I = 1'b1;
      taken = 1'b0;
      for (k = 0; k < 20 && !taken; k = k + 1) begin
        @(posedge CLK_I);
        #1 taken = (BUSY_O === 1'b1);
      end
      START_I = 1'b0;
      if (taken && !mute) q.push_back(expect_word(v, TWOS_COMP_I));
      for (k = 0; k < 400 && BUSY_O !== 1'b0; k = k + 1) @(posedge CLK_I);
      #1;
    end
  endtask
  task drain;
    begin
      for (k = 0; k < 500 && q.size() != 0; k = k + 1) @(posedge CLK_I);
      #1 check(q.size() == 0, "results missing");
    end
  endtask
  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end
  // Consumer with random stalls
  always @(posedge CLK_I) #1 RESULT_READY_I = stall ? 1'b0 : $random(seed);
  // Compare each accepted result with the oldest expectation
  always @(posedge CLK_I) begin
    if (TIMEOUT_O === 1'b1) n_tmo = n_tmo + 1;
    if (SETTLED_O === 1'b1) settle_seen = 1'b1;
    if (RESULT_VALID_O === 1'b1 && RESULT_READY_I === 1'b1) begin
      if (q.size() == 0) check(1'b0, "unexpected result");
      else check({OVER_O, UNDER_O, RESULT_O} === q.pop_front(), "result word");
    end
  end
  initial begin
    // About eight times the expected run of some 3200 cycles
    #100000 n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    seed = 96562;
    {RESETN_I, START_I, SLOW_GRADE_I, LATE_RELEASE_I, TWOS_COMP_I, RESULT_READY_I} = 6'h00;
    {mute, stall, settle_seen, ain, lat} = 0;
    {n_mismatch, n_compared, n_tmo} = 0;
    repeat (16) @(posedge CLK_I);
    #1 RESETN_I = 1'b1;
    for (p = 0; p < 2; p = p + 1) begin
      TWOS_COMP_I = p;
      for (i = 0; i < 40; i = i + 1) begin
        SLOW_GRADE_I = $random(seed);
        LATE_RELEASE_I = $random(seed);
        lat = $random(seed) & 8'h1F;
        a = (i == 0) ? -7 : (i == 1) ? 0 : (i == 2) ? 4095 : (i == 3) ? 4100 :
            ($random(seed) & 32'h1FFF) - 2048;
        convert(a, ok);
        check(ok, "start refused");
      end
      drain;
    end
    // Long conversion so the settling interval runs out while waiting
    SLOW_GRADE_I = 1'b0;
    LATE_RELEASE_I = 1'b0;
    lat = 8'h2C;
    convert(100, ok);
    check(ok && settle_seen, "settle flag never rose");
    lat = 8'h00;
    stall = 1'b1;
    n = 0;
    ok = 1'b1;
    while (ok && n < 12) begin
      convert(4095 - n, ok);
      if (ok) n = n + 1;
    end
    check(n >= 8 && n <= 10, "full buffer not refusing");
    stall = 1'b0;
    drain;
    mute = 1'b1;
    convert(5, ok);
    check(n_tmo == 1, "no timeout pulse");
    mute = 1'b0;
    drain;
    print_verdict;
  end
endmodule // test_conv_ctrl
